// ### rtl/miop_defs.svh
/*
 Register map, reset values and field positions for the I/O port block.
 Assumes an 8-bit CPU data bus and 8-bit register addresses.
*/
`ifndef MIOP_DEFS_SVH
`define MIOP_DEFS_SVH
`define MIOP_A_P0_DATA 8'hc0
`define MIOP_A_P1_DATA 8'hc1
`define MIOP_A_P2_DATA 8'hc2
`define MIOP_A_P3_DATA 8'hc3
`define MIOP_A_P0_DIR 8'hc8
`define MIOP_A_P1_DIR 8'hc9
`define MIOP_A_P2_DIR 8'hca
`define MIOP_A_P3_DIR 8'hcb
`define MIOP_A_P0_PU 8'hd0
`define MIOP_A_P1_PU 8'hd1
`define MIOP_A_P2_PU 8'hd2
`define MIOP_A_P0_OD 8'hd4
`define MIOP_A_P1_OD 8'hd5
`define MIOP_A_ALT 8'hd9
`define MIOP_A_KEY 8'hf0
`define MIOP_RST8 8'h00
`define MIOP_RST4 4'h0
`define MIOP_ALT_MASK 8'h5f
`define MIOP_ALT_BUZ 4
`define MIOP_ALT_PWM 6
`define MIOP_PIN_BUZ 4
`define MIOP_PIN_PWM 1
`define MIOP_ALT_EVT 3
`endif

// ### rtl/miop_pin.sv
/*
 One pad's drive logic: direction, open drain and pull-up.
 Assumes the caller registers the outputs where needed.
*/
`timescale 1ns/1ps
`default_nettype none
module miop_pin (
  input wire logic out_en,
  input wire logic data,
  input wire logic open_drain,
  input wire logic pull_sel,
  output logic oe,
  output logic o,
  output logic pull
);
  // Open drain: drive only a low, release on a one
  assign oe = out_en & ~(open_drain & data);
  assign o = data;
  assign pull = pull_sel & ~out_en;
endmodule : miop_pin
`default_nettype wire

// ### rtl/miop_pkg.sv
/*
 Types for the I/O port block.
 Assumes miop_defs.svh supplies the constants.
*/
package miop_pkg;
  typedef struct packed {
    logic [7:0] p0_data;
    logic [7:0] p1_data;
    logic [3:0] p2_data;
    logic [3:0] p3_data;
    logic [7:0] p0_dir;
    logic [7:0] p1_dir;
    logic [3:0] p2_dir;
    logic [3:0] p3_dir;
    logic [7:0] p0_pu;
    logic [7:0] p1_pu;
    logic [3:0] p2_pu;
    logic [7:0] p0_od;
    logic [7:0] p1_od;
    logic [7:0] alt;
    logic [7:0] key;
    logic [7:0] rdata;
  } miop_regs_t;
endpackage : miop_pkg

// ### rtl/miop_port.sv
/*
 Four general-purpose I/O ports with their control registers, pin
 multiplexing for interrupts, event input, buzzer and PWM, and key-scan
 input select. Assumes a synchronous single-cycle CPU register bus with
 write strobe and read strobe; pin inputs are synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "miop_defs.svh"
// Functional notes
// - Port zero is an 8-bit bidirectional port whose data latch sits at 0C0.
// - A direction bit of 1 makes an output, 0 an input, all clear at reset.
// - Port zero pull-up register at 0D0 connects each pull-up, reset 00.
// - The alternate-function register at 0D9 resets to zero, plain I/O.
// - A 1 in an alternate-function bit hands the pin to its peripheral.
// - Pins 0-2 feed irq 0-2, pin 3 the event input, 4 buzzer, 3.1 PWM.
// - Buzzer and PWM select bits at 0 keep pins as ports, reset -0-00000.
// - Port one has data 0C1, direction 0C9, pull-up 0D1, open drain 0D5.
// - Key-scan select on a port-one pin overrides its direction bit.
// - Port two is 4 bits with data 0C2, direction 0CA and pull-up 0D2.
// - Port three is 4 bits with data 0C3 and direction 0CB.
// - Registers read back the latch; pin reads return the pad level.
// - An enabled pull-up acts only while its pin is an input.
module miop_port (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic rd_pin,
  output logic [7:0] rdata,
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe,
  output logic [7:0] p0_pull,
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  output logic [7:0] p1_pull,
  input wire logic [3:0] p2_in,
  output logic [3:0] p2_out,
  output logic [3:0] p2_oe,
  output logic [3:0] p2_pull,
  input wire logic [3:0] p3_in,
  output logic [3:0] p3_out,
  output logic [3:0] p3_oe,
  input wire logic buzzer_output,
  input wire logic pwm_output,
  output logic external_irq_zero,
  output logic external_irq_one,
  output logic external_irq_two,
  output logic timer_event_input,
  output logic [7:0] key_scan_in
);
  miop_pkg::miop_regs_t r_q;
  miop_pkg::miop_regs_t r_d;
  logic [7:0] p0_src;
  logic [3:0] p3_src;
  logic [7:0] p0_dir_eff;
  logic [3:0] p3_dir_eff;
  logic [7:0] p0_oe_c;
  logic [7:0] p0_pu_c;
  logic [7:0] p1_oe_c;
  logic [7:0] p1_pu_c;
  logic [3:0] p2_oe_c;
  logic [3:0] p2_pu_c;
  logic [3:0] p3_oe_c;
  logic [7:0] p1_dir_eff;
  logic [7:0] irq_q;

  // Buzzer and PWM steal data and force output when selected
  always_comb begin
    p0_src = r_q.p0_data;
    p0_dir_eff = r_q.p0_dir;
    p3_src = r_q.p3_data;
    p3_dir_eff = r_q.p3_dir;
    if (r_q.alt[`MIOP_ALT_BUZ]) begin
      p0_src[`MIOP_PIN_BUZ] = buzzer_output;
      p0_dir_eff[`MIOP_PIN_BUZ] = 1'b1;
    end
    if (r_q.alt[`MIOP_ALT_PWM]) begin
      p3_src[`MIOP_PIN_PWM] = pwm_output;
      p3_dir_eff[`MIOP_PIN_PWM] = 1'b1;
    end
    // Inputs for interrupt and event pins are forced in
    for (int i = 0; i <= `MIOP_ALT_EVT; i++) begin
      if (r_q.alt[i]) begin
        p0_dir_eff[i] = 1'b0;
      end
    end
    // Key-scan pins are inputs whatever the direction bit says
    p1_dir_eff = r_q.p1_dir & ~r_q.key;
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_wide
      miop_pin u_p0 (
        .out_en(p0_dir_eff[g]),
        .data(p0_src[g]),
        .open_drain(r_q.p0_od[g]),
        .pull_sel(r_q.p0_pu[g]),
        .oe(p0_oe_c[g]),
        .o(),
        .pull(p0_pu_c[g])
      );
      miop_pin u_p1 (
        .out_en(p1_dir_eff[g]),
        .data(r_q.p1_data[g]),
        .open_drain(r_q.p1_od[g]),
        .pull_sel(r_q.p1_pu[g]),
        .oe(p1_oe_c[g]),
        .o(),
        .pull(p1_pu_c[g])
      );
    end
    for (g = 0; g < 4; g++) begin : g_narrow
      miop_pin u_p2 (
        .out_en(r_q.p2_dir[g]),
        .data(r_q.p2_data[g]),
        .open_drain(1'b0),
        .pull_sel(r_q.p2_pu[g]),
        .oe(p2_oe_c[g]),
        .o(),
        .pull(p2_pu_c[g])
      );
      miop_pin u_p3 (
        .out_en(p3_dir_eff[g]),
        .data(p3_src[g]),
        .open_drain(1'b0),
        .pull_sel(1'b0),
        .oe(p3_oe_c[g]),
        .o(),
        .pull()
      );
    end
  endgenerate

  always_comb begin
    r_d = r_q;
    if (wr_en) begin
      case (addr)
        `MIOP_A_P0_DATA: r_d.p0_data = wdata;
        `MIOP_A_P1_DATA: r_d.p1_data = wdata;
        `MIOP_A_P2_DATA: r_d.p2_data = wdata[3:0];
        `MIOP_A_P3_DATA: r_d.p3_data = wdata[3:0];
        `MIOP_A_P0_DIR: r_d.p0_dir = wdata;
        `MIOP_A_P1_DIR: r_d.p1_dir = wdata;
        `MIOP_A_P2_DIR: r_d.p2_dir = wdata[3:0];
        `MIOP_A_P3_DIR: r_d.p3_dir = wdata[3:0];
        `MIOP_A_P0_PU: r_d.p0_pu = wdata;
        `MIOP_A_P1_PU: r_d.p1_pu = wdata;
        `MIOP_A_P2_PU: r_d.p2_pu = wdata[3:0];
        `MIOP_A_P0_OD: r_d.p0_od = wdata;
        `MIOP_A_P1_OD: r_d.p1_od = wdata;
        `MIOP_A_ALT: r_d.alt = wdata & `MIOP_ALT_MASK;
        `MIOP_A_KEY: r_d.key = wdata;
        default: r_d.rdata = r_q.rdata;
      endcase
    end
    // Read data held until the next read
    if (rd_en) begin
      case (addr)
        `MIOP_A_P0_DATA: r_d.rdata = rd_pin ? p0_in : r_q.p0_data;
        `MIOP_A_P1_DATA: r_d.rdata = rd_pin ? p1_in : r_q.p1_data;
        `MIOP_A_P2_DATA:
          r_d.rdata = {4'h0, rd_pin ? p2_in : r_q.p2_data};
        `MIOP_A_P3_DATA:
          r_d.rdata = {4'h0, rd_pin ? p3_in : r_q.p3_data};
        `MIOP_A_P0_DIR: r_d.rdata = r_q.p0_dir;
        `MIOP_A_P1_DIR: r_d.rdata = r_q.p1_dir;
        `MIOP_A_P2_DIR: r_d.rdata = {4'h0, r_q.p2_dir};
        `MIOP_A_P3_DIR: r_d.rdata = {4'h0, r_q.p3_dir};
        `MIOP_A_P0_PU: r_d.rdata = r_q.p0_pu;
        `MIOP_A_P1_PU: r_d.rdata = r_q.p1_pu;
        `MIOP_A_P2_PU: r_d.rdata = {4'h0, r_q.p2_pu};
        `MIOP_A_P0_OD: r_d.rdata = r_q.p0_od;
        `MIOP_A_P1_OD: r_d.rdata = r_q.p1_od;
        `MIOP_A_ALT: r_d.rdata = r_q.alt;
        `MIOP_A_KEY: r_d.rdata = r_q.key;
        default: r_d.rdata = `MIOP_RST8;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '0;
      p0_out <= `MIOP_RST8;
      p0_oe <= `MIOP_RST8;
      p0_pull <= `MIOP_RST8;
      p1_out <= `MIOP_RST8;
      p1_oe <= `MIOP_RST8;
      p1_pull <= `MIOP_RST8;
      p2_out <= `MIOP_RST4;
      p2_oe <= `MIOP_RST4;
      p2_pull <= `MIOP_RST4;
      p3_out <= `MIOP_RST4;
      p3_oe <= `MIOP_RST4;
      irq_q <= `MIOP_RST8;
      key_scan_in <= `MIOP_RST8;
    end else begin
      r_q <= r_d;
      // Pad outputs lag the registers by one cycle to stay registered
      p0_out <= p0_src;
      p0_oe <= p0_oe_c;
      p0_pull <= p0_pu_c;
      p1_out <= r_q.p1_data;
      p1_oe <= p1_oe_c;
      p1_pull <= p1_pu_c;
      p2_out <= r_q.p2_data;
      p2_oe <= p2_oe_c;
      p2_pull <= p2_pu_c;
      p3_out <= p3_src;
      p3_oe <= p3_oe_c;
      // Peripheral inputs read as zero while the pin is plain I/O
      irq_q <= {4'h0, p0_in[3:0] & r_q.alt[3:0]};
      key_scan_in <= p1_in & r_q.key;
    end
  end

  assign rdata = r_q.rdata;
  assign external_irq_zero = irq_q[0];
  assign external_irq_one = irq_q[1];
  assign external_irq_two = irq_q[2];
  assign timer_event_input = irq_q[3];
endmodule : miop_port
`default_nettype wire

// ### tb/mcu_io_port_config_tb.sv
/* Bench for miop_port. Assumes miop_board models each port's pads. */
`timescale 1ns/1ps
`default_nettype none
module mcu_io_port_config_tb;
  logic clock, rst_b, wr_en, rd_en, rd_pin, buzzer_output, pwm_output;
  logic external_irq_zero, external_irq_one, external_irq_two;
  logic timer_event_input;
  logic [7:0] addr, wdata, rdata, p0_in, p0_out, p0_oe, p0_pull, r;
  logic [7:0] p1_in, p1_out, p1_oe, p1_pull, key_scan_in;
  logic [3:0] p2_in, p2_out, p2_oe, p2_pull, p3_in, p3_out, p3_oe;
  logic [15:0] e;
  int err_count, tests_run;
  logic [7:0] adr [15] = '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc8, 8'hc9,
    8'hca, 8'hcb, 8'hd0, 8'hd1, 8'hd2, 8'hd4, 8'hd5, 8'hd9, 8'hf0};
  miop_port i_miop_port (.clock, .rst_b, .addr, .wdata, .wr_en, .rd_en,
    .rd_pin, .rdata, .p0_in, .p0_out, .p0_oe, .p0_pull, .p1_in, .p1_out,
    .p1_oe, .p1_pull, .p2_in, .p2_out, .p2_oe, .p2_pull, .p3_in, .p3_out,
    .p3_oe, .buzzer_output, .pwm_output, .external_irq_zero,
    .external_irq_one, .external_irq_two, .timer_event_input, .key_scan_in);
  miop_board #(.W(8)) i_b0 (.oe(p0_oe), .o(p0_out), .pull(p0_pull),
    .ext(e[7:0]), .pin(p0_in));
  miop_board #(.W(8)) i_b1 (.oe(p1_oe), .o(p1_out), .pull(p1_pull),
    .ext(e[15:8]), .pin(p1_in));
  miop_board #(.W(4)) i_b2 (.oe(p2_oe), .o(p2_out), .pull(p2_pull),
    .ext(e[3:0]), .pin(p2_in));
  miop_board #(.W(4)) i_b3 (.oe(p3_oe), .o(p3_out), .pull(4'h0),
    .ext(e[7:4]), .pin(p3_in));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Alternate register keeps bits 5 and 7 at 0; small ports have 4 bits
  function automatic logic [7:0] msk(input logic [7:0] a);
    if (a == 8'hd9) return 8'h5f;
    return (a[3:0] inside {4'h2, 4'h3, 4'ha, 4'hb}) ? 8'h0f : 8'hff;
  endfunction : msk
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input logic w, rd, pin, input logic [7:0] a, d);
    @(posedge clock);
    #1 {wr_en, rd_en, rd_pin, addr, wdata} = {w, rd, pin, a, d};
    @(posedge clock);
    #1 {wr_en, rd_en} = 2'b00;
  endtask : cyc
  task automatic wr(input logic [7:0] a, d);
    cyc(1'b1, 1'b0, 1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic pin, logic [7:0] x);
    cyc(1'b0, 1'b1, pin, a, 8'h00);
    chk(rdata, x);
  endtask : rd
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    end_of_test();
  end
  initial begin
    {rst_b, wr_en, rd_en, rd_pin, buzzer_output, pwm_output} = 6'h00;
    {addr, wdata, e, r} = {8'h00, 8'h00, 16'h0000, 8'h2b};
    repeat (16) @(posedge clock);
    #1 rst_b = 1'b1;
    foreach (adr[i]) rd(adr[i], 1'b0, 8'h00);
    rd(8'h00, 1'b0, 8'h00);
    repeat (3) foreach (adr[i]) begin
      r = lfsr(r);
      wr(adr[i], r);
      rd(adr[i], 1'b0, r & msk(adr[i]));
    end
    r = lfsr(r);
    e = {r, lfsr(r)};
    wr(8'hd9, 8'h00);
    wr(8'hd4, 8'h00);
    wr(8'hc8, 8'hff);
    wr(8'hc0, r);
    rd(8'hc0, 1'b1, r);
    wr(8'hd4, 8'hff);
    rd(8'hc0, 1'b1, r & e[7:0]);
    wr(8'hc8, 8'h00);
    wr(8'hd0, 8'hff);
    rd(8'hc0, 1'b1, 8'hff);
    wr(8'hd0, 8'h00);
    // Open drain would release the buzzer pin on a one
    wr(8'hd4, 8'h00);
    {buzzer_output, pwm_output} = 2'b11;
    wr(8'hd9, 8'hff);
    rd(8'hd9, 1'b0, 8'h5f);
    chk({3'h0, p3_oe[1], p3_out[1], p0_oe[4], p0_out[4], timer_event_input},
      {3'h0, 4'hf, e[3]});
    wr(8'hd2, 8'h0f);
    wr(8'hc2, 8'h05);
    wr(8'hca, 8'h0c);
    @(posedge clock);
    #1 chk({p2_oe, p2_out}, 8'hc5);
    chk({p2_pull, p2_in}, 8'h37);
    wr(8'hd1, 8'h00);
    wr(8'hc9, 8'hff);
    wr(8'hf0, 8'hff);
    repeat (2) @(posedge clock);
    #1 chk(p1_oe, 8'h00);
    chk(key_scan_in, e[15:8]);
    rst_b = 1'b0;
    @(posedge clock);
    #1 rst_b = 1'b1;
    rd(8'hc9, 1'b0, 8'h00);
    end_of_test();
  end
endmodule : mcu_io_port_config_tb
`default_nettype wire

// ### tb/miop_board.sv
/* Pad model for one port. Assumes weak pull-ups, board level else. */
`timescale 1ns/1ps
`default_nettype none
module miop_board #(parameter int W = 8) (
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] o,
  input wire logic [W-1:0] pull,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pin
);
  // Driver wins over pull-up; a free pin shows the board level
  assign pin = (oe & o) | (~oe & pull) | (~oe & ~pull & ext);
endmodule : miop_board
`default_nettype wire

// ### tb/miop_port_properties.sv
/* Checker for the port block. Assumes it is bound to miop_port. */
`timescale 1ns/1ps
`default_nettype none
module miop_port_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic rd_pin,
  input wire logic [7:0] rdata,
  input wire logic [7:0] p0_in,
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p0_oe,
  input wire logic [7:0] p0_pull,
  input wire logic [7:0] p1_oe,
  input wire logic buzzer_output,
  input wire logic external_irq_zero
);
  logic [7:0] d_q, dr_q, od_q, pu_q, al_q, ks_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Shadow registers, so pad checks need no peeking inside
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {d_q, dr_q, od_q, pu_q, al_q, ks_q} <= 48'h0;
    end else if (wr_en) begin
      case (addr)
        8'hc0: d_q <= wdata;
        8'hc8: dr_q <= wdata;
        8'hd0: pu_q <= wdata;
        8'hd4: od_q <= wdata;
        8'hd9: al_q <= wdata;
        8'hf0: ks_q <= wdata;
        default: ;
      endcase
    end
  end
  property p_rst;
    $rose(rst_b) |-> p0_oe == 8'h00 && p0_pull == 8'h00;
  endproperty
  property p_oe;
    p0_oe[7] == $past(dr_q[7] & ~(od_q[7] & d_q[7]));
  endproperty
  property p_out;
    p0_oe[7] |-> p0_out[7] == $past(d_q[7] & ~od_q[7]);
  endproperty
  property p_pull;
    p0_pull[7] == $past(pu_q[7] & ~dr_q[7]);
  endproperty
  property p_irq;
    external_irq_zero == $past(p0_in[0] & al_q[0]);
  endproperty
  property p_buz;
    $past(al_q[4]) |-> p0_out[4] == $past(buzzer_output) &&
      p0_oe[4] == $past(~(od_q[4] & buzzer_output));
  endproperty
  property p_ks;
    $past(ks_q[0]) |-> !p1_oe[0];
  endproperty
  property p_rdl;
    rd_en && !rd_pin && addr == 8'hc0 |=> rdata == $past(d_q);
  endproperty
  a_rst: assert property (p_rst) else $error("pads not idle");
  a_oe: assert property (p_oe) else $error("pin enable");
  a_out: assert property (p_out) else $error("pin level");
  a_pull: assert property (p_pull) else $error("pull-up");
  a_irq: assert property (p_irq) else $error("irq pin");
  a_buz: assert property (p_buz) else $error("buzzer pin");
  a_ks: assert property (p_ks) else $error("key pin");
  a_rdl: assert property (p_rdl) else $error("latch read");
  c_od: cover property (p0_oe[7] && od_q[7]);
  c_alt: cover property (al_q[4] && al_q[0]);
  c_ks: cover property (ks_q[0] && dr_q[0]);
endmodule : miop_port_props
bind miop_port miop_port_props i_miop_port_props (.clock, .rst_b, .addr,
  .wdata, .wr_en, .rd_en, .rd_pin, .rdata, .p0_in, .p0_out, .p0_oe,
  .p0_pull, .p1_oe, .buzzer_output, .external_irq_zero);
`default_nettype wire
